// ===== verilog/ect_defs.svh
// Operation
// - Halt in debug unless debug-run bit set
// - Zero is BOTTOM, ones MAX, sequence top TOP
// - Update taken at BOTTOM or TOP per mode
// - Reset to periodic mode; eight modes exist
// - Enable starts counting at selected tick; readable
// - Periodic: count to compare, flag, restart
// - Compare below count: wrap at MAX, no flag
// - Event source holds pulses over one cycle
// - Time-out: first edge restarts, second stops
// - Time-out: flag if TOP before second edge
// - Frozen: edge restarts; reads, run writes ignored
// - Capture: free run, edge copies count, flag
// - Edge select: rising or falling capture
// - Capture: high-byte read clears flag
// - Software zeroes count entering capture mode
// - Frequency: edge captures and restarts; read clears
// - Pulse width: rise restarts, fall captures, flags
// - Pulse width: high-byte read clears flag
// - Source keeps edges two cycles apart
// - Combined: rise starts, fall captures, rise stops
// - Combined: read or clear rearms next sequence
// - Filter passes level after four equal samples
// - Every flag set also pulses event output
`ifndef ECT_DEFS_SVH
`define ECT_DEFS_SVH
// Device register indices
`define ECT_IDX_CONTROL_A 4'h0
`define ECT_IDX_CTRLB 4'h1
`define ECT_IDX_EVCTRL 4'h2
`define ECT_IDX_INTCTRL 4'h3
`define ECT_IDX_INTFLAGS 4'h4
`define ECT_IDX_STATUS 4'h5
`define ECT_IDX_DEBUG_CONTROL 4'h6
`define ECT_IDX_CNT 4'h7
`define ECT_IDX_CAPTURE_COMPARE 4'h8
// Field positions
`define ECT_BIT_ENABLE 0
`define ECT_BIT_CLOCK_SELECT_LO 1
`define ECT_BIT_CAPTEI 0
`define ECT_BIT_EDGE 4
`define ECT_BIT_FILTER 6
`define ECT_BIT_CAPTURE_FLAG 0
`define ECT_BIT_RUN 0
`define ECT_BIT_DEBUG_RUN 0
// Clock select codes
`define ECT_CLK_DIV1 2'h0
`define ECT_CLK_DIV2 2'h1
`define ECT_CLK_TCA 2'h2
// Mode codes
`define ECT_MODE_PERIODIC 3'h0
`define ECT_MODE_TIMEOUT 3'h1
`define ECT_MODE_CAPTURE 3'h2
`define ECT_MODE_FREQ 3'h3
`define ECT_MODE_PW 3'h4
`define ECT_MODE_FREQPW 3'h5
`define ECT_MODE_SINGLE 3'h6
`define ECT_MODE_PWM8 3'h7
// Reset values and limits
`define ECT_CNT_BOTTOM 16'h0000
`define ECT_CNT_MAX 16'hffff
`define ECT_COMPARE_RESET 16'h0000
`define ECT_FILTER_LEN 4
// Host APB map (byte addresses)
`define ECT_APB_DEV_LIMIT 8'h24
`define ECT_APB_HOST_STATUS 8'h40
`endif

// ===== verilog/ect_pkg.sv
`default_nettype none
`include "ect_defs.svh"
package ect_pkg;
   typedef logic [2:0] ect_mode_t;
   // Combined-mode sequence states
   typedef enum logic [3:0] {
      ECT_FP_IDLE = 4'b0001,
      ECT_FP_HIGH = 4'b0010,
      ECT_FP_LOW = 4'b0100,
      ECT_FP_DONE = 4'b1000
   } ect_fp_e;
   // Host transfer states
   typedef enum logic [2:0] {
      ECT_H_IDLE = 3'b001,
      ECT_H_WAIT = 3'b010,
      ECT_H_DONE = 3'b100
   } ect_host_e;
endpackage : ect_pkg
`default_nettype wire

// ===== verilog/ect_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ect_link_if;
   logic req;
   logic we;
   logic [3:0] addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic ack;
   logic event_in;
   logic event_out;
   logic dbg_halt;
   logic tca_tick;
   logic irq;
   modport dev (input req, we, addr, wdata, event_in, dbg_halt, tca_tick,
                output rdata, ack, event_out, irq);
   modport host (output req, we, addr, wdata, event_in, dbg_halt, tca_tick,
                 input rdata, ack, event_out, irq);
endinterface : ect_link_if
`default_nettype wire

// ===== verilog/ect_filter.sv
`timescale 1ns/1ps
`default_nettype none
module ect_filter
   import ect_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic en,
   input wire logic din,
   output logic dout
);
   logic [`ECT_FILTER_LEN-1:0] hist_reg;
   wire all_hi = &hist_reg;
   wire all_lo = ~|hist_reg;

   // Four-sample history; with en set, level passes only when all agree
   always_ff @(posedge clk) begin
      if (srst) begin
         hist_reg <= '0;
         dout <= 1'b0;
      end else if (ce) begin
         hist_reg <= {hist_reg[`ECT_FILTER_LEN-2:0], din};
         if (!en)
            dout <= din;
         else if (all_hi || all_lo)
            dout <= hist_reg[`ECT_FILTER_LEN-1];
      end
   end
endmodule : ect_filter
`default_nettype wire

// ===== verilog/ect_timer.sv
`timescale 1ns/1ps
`default_nettype none
module ect_timer
   import ect_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   ect_link_if.dev link,
   output logic running
);
   // Control registers
   logic enable_reg;
   logic [1:0] clock_select_reg;
   ect_mode_t mode_reg;
   logic captei_reg, edge_reg, filter_reg, capture_ie_reg, dbg_run_reg;
   logic capture_flag_reg, run_reg, div_reg, prev_reg, to_armed_reg, to_frozen_reg;
   logic [15:0] cnt_reg, cap_cmp_reg;
   ect_fp_e fp_reg;
   logic filt_lvl;

   ect_filter u_filter (
      .clk(clk),
      .srst(srst),
      .ce(ce),
      .en(filter_reg),
      .din(link.event_in),
      .dout(filt_lvl)
   );

   // Activity: debug halt freezes counting and event detection unless debug-run is set
   wire active = !link.dbg_halt || dbg_run_reg;
   wire go = enable_reg && active;
   // Tick selection
   wire tick = go && ((clock_select_reg == `ECT_CLK_DIV1) ||
                      (clock_select_reg == `ECT_CLK_DIV2 && div_reg) ||
                      (clock_select_reg == `ECT_CLK_TCA && link.tca_tick));

   // Edge detection on filtered level
   wire rise = filt_lvl && !prev_reg;
   wire fall = !filt_lvl && prev_reg;
   wire ev_ok = go && captei_reg; // events ignored while halted
   wire sel_edge = ev_ok && (edge_reg ? fall : rise);
   wire ev_rise = ev_ok && rise;
   wire ev_fall = ev_ok && fall;

   // Counter landmarks
   wire at_top = cnt_reg == cap_cmp_reg;
   wire at_max = cnt_reg == `ECT_CNT_MAX;
   // Next count value; rolls from MAX back to BOTTOM
   wire [15:0] cnt_inc = at_max ? `ECT_CNT_BOTTOM : cnt_reg + 16'h0001;

   // Register access decode
   wire wr = link.req && link.we;
   wire rd = link.req && !link.we;
   wire wr_control_a = wr && link.addr == `ECT_IDX_CONTROL_A;
   wire wr_ctrlb = wr && link.addr == `ECT_IDX_CTRLB;
   wire wr_evctrl = wr && link.addr == `ECT_IDX_EVCTRL;
   wire wr_intctrl = wr && link.addr == `ECT_IDX_INTCTRL;
   wire wr_flags = wr && link.addr == `ECT_IDX_INTFLAGS;
   wire wr_status = wr && link.addr == `ECT_IDX_STATUS;
   wire wr_dbg = wr && link.addr == `ECT_IDX_DEBUG_CONTROL;
   wire wr_cnt = wr && link.addr == `ECT_IDX_CNT;
   wire wr_cap_cmp = wr && link.addr == `ECT_IDX_CAPTURE_COMPARE;
   wire frozen = mode_reg == `ECT_MODE_TIMEOUT && to_frozen_reg;
   // A 16-bit read of the capture includes its high byte
   wire rd_cap_cmp = rd && link.addr == `ECT_IDX_CAPTURE_COMPARE && !frozen;
   wire flag_clr = wr_flags && link.wdata[`ECT_BIT_CAPTURE_FLAG];

   // Mode behaviour: next count, capture, flag set
   logic [15:0] cnt_next, cap_cmp_next;
   logic set_flag, run_next, armed_next, frozen_next;
   ect_fp_e fp_next;
   always_comb begin
      cnt_next = cnt_reg;
      cap_cmp_next = cap_cmp_reg;
      set_flag = 1'b0;
      run_next = run_reg;
      armed_next = to_armed_reg;
      frozen_next = to_frozen_reg;
      fp_next = fp_reg;
      unique case (mode_reg)
         `ECT_MODE_PERIODIC: begin
            if (tick) begin
               // Update at TOP; a compare below count rolls through MAX
               cnt_next = at_top ? `ECT_CNT_BOTTOM : cnt_inc;
               set_flag = cnt_next == cap_cmp_reg; // flag as the count arrives at TOP
            end
         end
         `ECT_MODE_TIMEOUT: begin
            if (tick && !to_frozen_reg)
               cnt_next = cnt_reg + 16'h0001; // wraps at MAX
            if (tick && !to_frozen_reg && to_armed_reg && cnt_inc == cap_cmp_reg)
               set_flag = 1'b1;
            if (sel_edge) begin
               if (to_armed_reg) begin
                  armed_next = 1'b0; // second edge stops
                  frozen_next = 1'b1;
               end else begin
                  cnt_next = `ECT_CNT_BOTTOM; // first edge, or edge in frozen state
                  armed_next = 1'b1;
                  frozen_next = 1'b0;
               end
            end
            run_next = go && !frozen_next;
         end
         `ECT_MODE_CAPTURE: begin
            if (tick)
               cnt_next = cnt_reg + 16'h0001; // BOTTOM to MAX forever
            if (sel_edge) begin
               cap_cmp_next = cnt_reg;
               set_flag = 1'b1;
            end
         end
         `ECT_MODE_FREQ: begin
            if (tick)
               cnt_next = cnt_reg + 16'h0001;
            if (sel_edge) begin
               cap_cmp_next = cnt_reg;
               cnt_next = `ECT_CNT_BOTTOM;
               set_flag = 1'b1;
            end
         end
         `ECT_MODE_PW: begin
            if (tick)
               cnt_next = cnt_reg + 16'h0001;
            if (ev_rise)
               cnt_next = `ECT_CNT_BOTTOM;
            else if (ev_fall) begin
               cap_cmp_next = cnt_reg;
               set_flag = 1'b1;
            end
         end
         `ECT_MODE_FREQPW: begin
            if (tick && (fp_reg == ECT_FP_HIGH || fp_reg == ECT_FP_LOW))
               cnt_next = cnt_reg + 16'h0001;
            unique case (fp_reg)
               ECT_FP_IDLE: if (ev_rise) begin
                  cnt_next = `ECT_CNT_BOTTOM;
                  fp_next = ECT_FP_HIGH;
               end
               ECT_FP_HIGH: if (ev_fall) begin
                  cap_cmp_next = cnt_reg;
                  fp_next = ECT_FP_LOW;
               end
               ECT_FP_LOW: if (ev_rise) begin
                  set_flag = 1'b1; // counter stops here
                  fp_next = ECT_FP_DONE;
               end
               ECT_FP_DONE: if (rd_cap_cmp || flag_clr)
                  fp_next = ECT_FP_IDLE;
               default: fp_next = ECT_FP_IDLE;
            endcase
            run_next = go && (fp_next == ECT_FP_HIGH || fp_next == ECT_FP_LOW);
         end
         default: begin
            // Single-shot and 8-bit PWM count here, restarting from BOTTOM at TOP
            if (tick)
               cnt_next = at_top ? `ECT_CNT_BOTTOM : cnt_reg + 16'h0001;
         end
      endcase
      if (mode_reg != `ECT_MODE_TIMEOUT && mode_reg != `ECT_MODE_FREQPW)
         run_next = go;
   end

   // Read mux
   logic [15:0] rd_mux;
   always_comb begin
      unique case (link.addr)
         `ECT_IDX_CONTROL_A: rd_mux = {13'h0000, clock_select_reg, enable_reg};
         `ECT_IDX_CTRLB: rd_mux = {13'h0000, mode_reg};
         `ECT_IDX_EVCTRL: rd_mux = {9'h000, filter_reg, 1'b0, edge_reg, 3'h0, captei_reg};
         `ECT_IDX_INTCTRL: rd_mux = {15'h0000, capture_ie_reg};
         `ECT_IDX_INTFLAGS: rd_mux = {15'h0000, capture_flag_reg};
         `ECT_IDX_STATUS: rd_mux = {15'h0000, run_reg};
         `ECT_IDX_DEBUG_CONTROL: rd_mux = {15'h0000, dbg_run_reg};
         `ECT_IDX_CNT: rd_mux = cnt_reg;
         `ECT_IDX_CAPTURE_COMPARE: rd_mux = cap_cmp_reg;
         default: rd_mux = 16'h0000;
      endcase
   end

   // Control registers, written by the bus
   always_ff @(posedge clk) begin
      if (srst) begin
         enable_reg <= 1'b0;
         clock_select_reg <= `ECT_CLK_DIV1;
         mode_reg <= `ECT_MODE_PERIODIC;
         captei_reg <= 1'b0;
         edge_reg <= 1'b0;
         filter_reg <= 1'b0;
         capture_ie_reg <= 1'b0;
         dbg_run_reg <= 1'b0;
      end else if (ce) begin
         if (wr_control_a) begin
            enable_reg <= link.wdata[`ECT_BIT_ENABLE];
            clock_select_reg <= link.wdata[`ECT_BIT_CLOCK_SELECT_LO+1:`ECT_BIT_CLOCK_SELECT_LO];
         end
         if (wr_ctrlb)
            mode_reg <= link.wdata[2:0];
         if (wr_evctrl) begin
            captei_reg <= link.wdata[`ECT_BIT_CAPTEI];
            edge_reg <= link.wdata[`ECT_BIT_EDGE];
            filter_reg <= link.wdata[`ECT_BIT_FILTER];
         end
         if (wr_intctrl)
            capture_ie_reg <= link.wdata[`ECT_BIT_CAPTURE_FLAG];
         if (wr_dbg)
            dbg_run_reg <= link.wdata[`ECT_BIT_DEBUG_RUN];
      end
   end

   // Counting state; bus writes take priority over counting
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_reg <= `ECT_CNT_BOTTOM;
         cap_cmp_reg <= `ECT_COMPARE_RESET;
         div_reg <= 1'b0;
         prev_reg <= 1'b0;
         run_reg <= 1'b0;
         to_armed_reg <= 1'b0;
         to_frozen_reg <= 1'b0;
         fp_reg <= ECT_FP_IDLE;
      end else if (ce) begin
         if (go)
            div_reg <= !div_reg;
         if (active)
            prev_reg <= filt_lvl;
         cnt_reg <= wr_cnt ? link.wdata : cnt_next;
         cap_cmp_reg <= wr_cap_cmp ? link.wdata : cap_cmp_next;
         to_armed_reg <= armed_next;
         to_frozen_reg <= frozen_next;
         fp_reg <= wr_ctrlb ? ECT_FP_IDLE : fp_next;
         // Run bit written outside the frozen state only
         run_reg <= (wr_status && !frozen) ? link.wdata[`ECT_BIT_RUN] : run_next;
      end
   end

   // Flag, event pulse, interrupt and bus answer; set beats clear
   always_ff @(posedge clk) begin
      if (srst) begin
         capture_flag_reg <= 1'b0;
         link.event_out <= 1'b0;
         link.irq <= 1'b0;
         link.ack <= 1'b0;
         link.rdata <= 16'h0000;
         running <= 1'b0;
      end else if (ce) begin
         capture_flag_reg <= set_flag || (capture_flag_reg && !flag_clr && !rd_cap_cmp);
         link.event_out <= set_flag;
         link.irq <= capture_ie_reg && (set_flag || (capture_flag_reg && !flag_clr && !rd_cap_cmp));
         link.ack <= link.req;
         if (rd)
            link.rdata <= rd_mux;
         running <= run_next;
      end
   end
endmodule : ect_timer
`default_nettype wire

// ===== verilog/ect_host.sv
`timescale 1ns/1ps
`default_nettype none
module ect_host
   import ect_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   ect_link_if.host link,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ev_src,
   input wire logic dbg_halt_in,
   input wire logic tca_tick_in,
   output logic irq_out,
   output logic event_pulse
);
   ect_host_e st_reg;
   logic [7:0] ev_count_reg;

   // Decode of the APB request
   wire access = psel && penable;
   wire to_dev = paddr < `ECT_APB_DEV_LIMIT && paddr[1:0] == 2'h0;
   wire to_stat = paddr == `ECT_APB_HOST_STATUS;

   // Link drive and device-event bookkeeping
   always_ff @(posedge clk) begin
      if (srst) begin
         link.event_in <= 1'b0;
         link.dbg_halt <= 1'b0;
         link.tca_tick <= 1'b0;
         irq_out <= 1'b0;
         event_pulse <= 1'b0;
         ev_count_reg <= 8'h00;
      end else if (ce) begin
         link.event_in <= ev_src; // caller holds pulses long enough
         link.dbg_halt <= dbg_halt_in;
         link.tca_tick <= tca_tick_in;
         irq_out <= link.irq;
         event_pulse <= link.event_out;
         if (link.event_out)
            ev_count_reg <= ev_count_reg + 8'h01;
      end
   end

   // APB slave and forwarding of device accesses
   always_ff @(posedge clk) begin
      if (srst) begin
         st_reg <= ECT_H_IDLE;
         link.req <= 1'b0;
         link.we <= 1'b0;
         link.addr <= 4'h0;
         link.wdata <= 16'h0000;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (ce) begin
         link.req <= 1'b0;
         unique case (st_reg)
            ECT_H_IDLE: begin
               if (access && to_dev) begin
                  link.req <= 1'b1;
                  link.we <= pwrite;
                  link.addr <= paddr[5:2];
                  link.wdata <= pwdata[15:0];
                  st_reg <= ECT_H_WAIT;
               end else if (access) begin
                  prdata <= to_stat ? {23'h000000, link.irq, ev_count_reg} : 32'h0000_0000;
                  pslverr <= !to_stat || pwrite;
                  pready <= 1'b1;
                  st_reg <= ECT_H_DONE;
               end
            end
            ECT_H_WAIT: begin
               if (link.ack) begin
                  prdata <= {16'h0000, link.rdata};
                  pslverr <= 1'b0;
                  pready <= 1'b1;
                  st_reg <= ECT_H_DONE;
               end
            end
            ECT_H_DONE: begin
               pready <= 1'b0;
               pslverr <= 1'b0;
               st_reg <= ECT_H_IDLE;
            end
            default: st_reg <= ECT_H_IDLE;
         endcase
      end
   end
endmodule : ect_host
`default_nettype wire

// ===== testbench/ect_link_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "ect_defs.svh"
module ect_link_assertions (
   input wire logic clk,
   input wire logic srst,
   input wire logic req,
   input wire logic we,
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   input wire logic [15:0] rdata,
   input wire logic ack,
   input wire logic event_out,
   input wire logic irq,
   input wire logic dbg_halt
);
   logic [2:0] mode_reg;
   logic run_dbg_reg;
   wire logic cap_mode;
   // Capture-style modes whose capture read clears the flag
   assign cap_mode = mode_reg inside {`ECT_MODE_CAPTURE, `ECT_MODE_FREQ, `ECT_MODE_PW, `ECT_MODE_FREQPW};
   // Shadow of the mode and debug-run bits as written over the link
   always_ff @(posedge clk) begin
      if (srst) begin
         mode_reg <= `ECT_MODE_PERIODIC;
         run_dbg_reg <= 1'b0;
      end else if (req && we) begin
         if (addr == 4'h1) mode_reg <= wdata[2:0];
         if (addr == 4'h6) run_dbg_reg <= wdata[0];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   a_ack_follows_req: assert property (req |=> ack)
      else $error("no acknowledge one cycle after request");
   a_ack_has_cause: assert property (ack |-> $past(req))
      else $error("acknowledge without request");
   a_req_one_cycle: assert property (req |=> !req)
      else $error("request longer than one cycle");
   a_rdata_with_ack: assert property ($changed(rdata) |-> ack)
      else $error("read data moved without acknowledge");
   a_event_one_cycle: assert property (event_out |=> !event_out)
      else $error("event output longer than one cycle");
   a_event_on_flag: assert property ($rose(irq) |-> ##[0:1] event_out)
      else $error("flag set without event pulse");
   a_irq_fall_cause: assert property ($fell(irq) |-> $past(req) || $past(req, 2) || $past(req, 3))
      else $error("interrupt dropped without register access");
   a_read_clears_flag: assert property (req && !we && addr == 4'h8 && irq && cap_mode |-> ##[1:3] !irq)
      else $error("capture read did not clear flag");
   a_write_clears_flag: assert property (req && we && addr == 4'h4 && wdata[0] |-> ##[1:3] !irq)
      else $error("flag write did not clear flag");
   a_halt_quiet: assert property ((dbg_halt && !run_dbg_reg) [*3] |-> !event_out)
      else $error("event pulse during debug halt");
endmodule // ect_link_assertions
`default_nettype wire

// ===== testbench/event_capture_timer_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ect_defs.svh"
module event_capture_timer_bench;
   localparam logic [7:0] a_ctl = 8'h00, a_mode = 8'h04, a_evc = 8'h08, a_ien = 8'h0c, a_flg = 8'h10;
   localparam logic [7:0] a_sts = 8'h14, a_dbg = 8'h18, a_count = 8'h1c, a_ccv = 8'h20, a_host = 8'h40;
   logic clk = 1'b0, srst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdv;
   logic pready, pslverr, irq_out, event_pulse, running, errv;
   logic ev_src = 1'b0, dbg_halt_in = 1'b0, tca_tick_in = 1'b0;
   int errors = 0, check_count = 0, pulse_seen = 0;
   // Free-running system clock
   always #4 clk = ~clk;
   ect_link_if link ();
   ect_host ect_host_inst (.clk(clk), .srst(srst), .ce(1'b1), .link(link), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ev_src(ev_src), .dbg_halt_in(dbg_halt_in), .tca_tick_in(tca_tick_in), .irq_out(irq_out),
      .event_pulse(event_pulse));
   ect_timer ect_timer_inst (.clk(clk), .srst(srst), .ce(1'b1), .link(link), .running(running));
   ect_link_assertions ect_link_assertions_inst (.clk(clk), .srst(srst), .req(link.req), .we(link.we),
      .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack), .event_out(link.event_out),
      .irq(link.irq), .dbg_halt(link.dbg_halt));
   // Count event pulses seen at the host side
   always @(posedge clk) begin
      if (event_pulse === 1'b1) pulse_seen <= pulse_seen + 1;
   end
   task close_out;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer, held until pready is sampled high
   task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      if (n >= 40) begin
         errors++;
         $display("unexpected at %0t: no bus answer", $time);
         close_out();
      end
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task wr(input logic [7:0] a, input logic [15:0] d);
      xfer(1'b1, a, {16'h0, d});
   endtask
   task rd(input logic [7:0] a, input logic [15:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rdv, {16'h0, e});
   endtask
   // Borrowed-prescaler ticks make every count exact
   task tick(input int n);
      repeat (n) begin
         tca_tick_in <= 1'b1;
         @(posedge clk);
         tca_tick_in <= 1'b0;
         @(posedge clk);
      end
   endtask
   // Event level held well beyond the filter length
   task ev(input logic v);
      ev_src <= v;
      repeat (12) @(posedge clk);
   endtask
   task irq_is(input logic e);
      repeat (3) @(posedge clk);
      chk({31'h0, irq_out}, {31'h0, e});
   endtask
   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      // Reset state, mode codes and refused addresses
      rd(a_mode, 16'h0);
      rd(a_count, 16'h0);
      chk({31'h0, running}, 32'h0);
      for (int m = 0; m < 8; m++) begin
         wr(a_mode, 16'(m));
         rd(a_mode, 16'(m));
      end
      xfer(1'b0, 8'h80, 32'h0);
      chk({31'h0, errv}, 32'h1);
      xfer(1'b1, a_host, 32'h1);
      chk({31'h0, errv}, 32'h1);
      // Periodic interrupt at TOP, then restart from zero
      wr(a_mode, {13'h0, `ECT_MODE_PERIODIC});
      wr(a_ccv, 16'h0003);
      wr(a_ien, 16'h0001);
      wr(a_ctl, {13'h0, `ECT_CLK_TCA, 1'b1});
      chk({31'h0, running}, 32'h1);
      tick(3);
      rd(a_count, 16'h0003);
      irq_is(1'b1);
      tick(1);
      rd(a_count, 16'h0000);
      wr(a_flg, 16'h0001);
      irq_is(1'b0);
      // TOP below count: run to MAX and wrap silently
      wr(a_count, 16'hfffe);
      wr(a_ccv, 16'h0001);
      tick(2);
      rd(a_count, 16'h0000);
      irq_is(1'b0);
      tick(1);
      irq_is(1'b1);
      wr(a_flg, 16'h0001);
      // Debug halt freezes counting unless debug-run is set
      wr(a_ccv, 16'h0100);
      wr(a_count, 16'h0010);
      dbg_halt_in <= 1'b1;
      tick(2);
      rd(a_count, 16'h0010);
      wr(a_dbg, 16'h0001);
      tick(2);
      rd(a_count, 16'h0012);
      dbg_halt_in <= 1'b0;
      wr(a_dbg, 16'h0000);
      // Capture on rising, then falling edges
      wr(a_mode, {13'h0, `ECT_MODE_CAPTURE});
      wr(a_count, 16'h0000);
      wr(a_evc, 16'h0001);
      tick(5);
      ev(1'b1);
      irq_is(1'b1);
      rd(a_ccv, 16'h0005);
      irq_is(1'b0);
      wr(a_evc, 16'h0011);
      tick(2);
      ev(1'b0);
      tick(1);
      ev(1'b1);
      rd(a_ccv, 16'h0007);
      // Frequency: each rise captures and restarts
      wr(a_mode, {13'h0, `ECT_MODE_FREQ});
      wr(a_evc, 16'h0001);
      ev(1'b0);
      ev(1'b1);
      wr(a_flg, 16'h0001);
      tick(4);
      ev(1'b0);
      ev(1'b1);
      rd(a_count, 16'h0000);
      rd(a_ccv, 16'h0004);
      irq_is(1'b0);
      ev(1'b0);
      // Pulse width: rise restarts, fall captures
      wr(a_mode, {13'h0, `ECT_MODE_PW});
      tick(3);
      ev(1'b1);
      tick(6);
      ev(1'b0);
      irq_is(1'b1);
      rd(a_ccv, 16'h0006);
      irq_is(1'b0);
      // Combined: rise starts, fall captures, rise stops
      wr(a_mode, {13'h0, `ECT_MODE_FREQPW});
      ev(1'b1);
      tick(4);
      ev(1'b0);
      irq_is(1'b0);
      tick(3);
      ev(1'b1);
      irq_is(1'b1);
      tick(2);
      rd(a_count, 16'h0007);
      rd(a_ccv, 16'h0004);
      irq_is(1'b0);
      // Time-out: second edge stops, frozen state ignores run writes
      wr(a_mode, {13'h0, `ECT_MODE_TIMEOUT});
      wr(a_ccv, 16'h0003);
      ev(1'b0);
      ev(1'b1);
      tick(2);
      ev(1'b0);
      ev(1'b1);
      irq_is(1'b0);
      tick(2);
      rd(a_count, 16'h0002);
      wr(a_sts, 16'h0001);
      tick(1);
      rd(a_count, 16'h0002);
      ev(1'b0);
      ev(1'b1);
      tick(3);
      rd(a_count, 16'h0003);
      irq_is(1'b1);
      wr(a_flg, 16'h0001);
      // Filter rejects a short glitch, passes a steady level
      wr(a_mode, {13'h0, `ECT_MODE_CAPTURE});
      wr(a_count, 16'h0000);
      wr(a_evc, 16'h0041);
      ev(1'b0);
      ev_src <= 1'b1;
      repeat (2) @(posedge clk);
      ev(1'b0);
      irq_is(1'b0);
      ev(1'b1);
      irq_is(1'b1);
      rd(a_ccv, 16'h0000);
      // One event pulse for every flag set
      rd(a_host, 16'h000a);
      chk(32'(pulse_seen), 32'h0000_000a);
      close_out();
   end
endmodule // event_capture_timer_bench
`default_nettype wire
